// ===== thbp_pkg.sv
// Package for the timer host bus port: widths, codes and reset values.
// Assumes a single 10 MHz core clock and an asynchronous active-high reset.
`default_nettype none
package thbp_pkg;
  // Bus and register geometry.
  localparam int          THBP_BUS_W     = 16;
  localparam int          THBP_BYTE_W    = 8;
  localparam int          THBP_NCNT      = 5;
  localparam int          THBP_PTR_W     = 8;
  localparam int          THBP_NREG      = 256;
  // Bit position of the bus width bit in the master mode register.
  localparam int          THBP_WIDTH_BIT = 14;
  // Lowest bus line that doubles as an extra gate input in 8-bit mode.
  localparam int          THBP_GATE_LO   = 8;
  // Data pointer value selecting the master mode register.
  localparam logic [7:0]  THBP_PTR_MM    = 8'h17;
  // Reset values.
  localparam logic [15:0] THBP_MM_RST    = 16'h0000;
  localparam logic [7:0]  THBP_PTR_RST   = 8'h00;
  localparam logic [7:0]  THBP_CMD_RST   = 8'h00;
  localparam logic [15:0] THBP_ZERO16    = 16'h0000;
  localparam logic [7:0]  THBP_ZERO8     = 8'h00;
  // Command code prefix that loads the data pointer (low bits = pointer).
  localparam logic [2:0]  THBP_CMD_LDPTR = 3'h0;
  // Port select codes on the control/data line.
  localparam logic        THBP_PORT_DATA = 1'b0;
  localparam logic        THBP_PORT_CTRL = 1'b1;
  // Strobe phases seen by the port.
  typedef enum logic [1:0] {
    THBP_IDLE,
    THBP_WRITE,
    THBP_READ
  } thbp_phase_t;
endpackage
`default_nettype wire

// ===== thbp_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to core_clk_in.
`default_nettype none
module thbp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // Raw pin levels and their synchronised copies.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // First stage; read only by the second stage.
  logic [W-1:0] meta_r;

  // Both stages reset to the idle level of the pins.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== thbp_port.sv
// Host bus port of a five-counter timer: strobes, port select and bus.
// Assumes host strobes are asynchronous pins and the core clock is faster.
`default_nettype none
module thbp_port
  import thbp_pkg::*;
#(
  parameter int NCNT = THBP_NCNT
) (
  // Clock and reset.
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  // Host strobes, all active low, and the control/data select (high = control).
  input  wire logic                  chip_sel_n_in,
  input  wire logic                  rd_n_in,
  input  wire logic                  wr_n_in,
  input  wire logic                  ctrl_data_in,
  // Host data bus, split into its three signals.
  input  wire logic [THBP_BUS_W-1:0] host_bus_line_in,
  output logic      [THBP_BUS_W-1:0] host_bus_line_out,
  output logic                       host_bus_line_oe_out,
  // Status from the counter core, shown on a control read.
  input  wire logic [THBP_BYTE_W-1:0] status_in,
  // Core-side view of the port.
  output logic      [THBP_BYTE_W-1:0] command_out,
  output logic                        command_stb_out,
  output logic      [THBP_PTR_W-1:0]  data_ptr_out,
  output logic                        bus_width_bit_out,
  output logic      [NCNT-1:0]        gate_enable_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  // Synchronised strobes and bus.
  logic                  cs_n_s;
  logic                  rd_n_s;
  logic                  wr_n_s;
  logic                  cd_s;
  logic [THBP_BUS_W-1:0] bus_s;

  // Strobes idle high; the bus idles high as the pull-ups leave it.
  thbp_sync #(.W(4), .RST_VAL(4'hF)) u_sync_strb (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    ({chip_sel_n_in, rd_n_in, wr_n_in, ctrl_data_in}),
    .sync_out    ({cs_n_s, rd_n_s, wr_n_s, cd_s})
  );

  thbp_sync #(.W(THBP_BUS_W), .RST_VAL(16'hFFFF)) u_sync_bus (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    (host_bus_line_in),
    .sync_out    (bus_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Strobe qualification.

  // Qualified strobe levels.
  logic        wr_act;
  logic        rd_act;
  logic        wr_act_r;
  logic        wr_fire;
  logic        rd_act_r;
  logic        rd_fire;
  thbp_phase_t phase;

  // strobes gated by select: with chip select high neither counts.
  // write qualified: write only acts while chip select is low.
  always_comb begin
    wr_act = !cs_n_s && !wr_n_s;
    rd_act = !cs_n_s && !rd_n_s;
    // strobes exclusive: the host keeps them apart, write wins if not.
    if (wr_act) begin
      phase = THBP_WRITE;
    end else if (rd_act) begin
      phase = THBP_READ;
    end else begin
      phase = THBP_IDLE;
    end
  end

  // Previous cycle's qualified strobes, for edge detection.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
    end else begin
      wr_act_r <= (phase == THBP_WRITE);
      rd_act_r <= (phase == THBP_READ);
    end
  end

  // Data is taken at the trailing edge of write, when the bus is settled.
  assign wr_fire = wr_act_r && (phase != THBP_WRITE);
  // A read ends at the trailing edge of read; a data read flips the byte toggle there in 8-bit mode.
  assign rd_fire = rd_act_r && (phase != THBP_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Command register and data pointer.

  // Command register, its strobe and the pointer, plus the byte toggle.
  logic [THBP_BYTE_W-1:0] command_r;
  logic                   command_stb_r;
  logic [THBP_PTR_W-1:0]  ptr_r;
  logic                   hi_byte_r;
  logic                   ctrl_wr;
  logic                   data_wr;
  logic [THBP_BUS_W-1:0]  wr_bus_r;  // Bus value seen during the write.
  logic [THBP_BUS_W-1:0]  mm_r;      // Master mode word.

  // write target: the port select picks command or data space.
  assign ctrl_wr = wr_fire && (cd_s == THBP_PORT_CTRL);
  assign data_wr = wr_fire && (cd_s == THBP_PORT_DATA);

  // Hold the bus while the write lasts, because a host may drop its data
  // as the strobe rises, before the synchronised trailing edge is seen.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_bus_r <= THBP_ZERO16;
    end else if (phase == THBP_WRITE) begin
      wr_bus_r <= bus_s;
    end
  end

  // command load: control writes land in the command register.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      command_r     <= THBP_CMD_RST;
      command_stb_r <= 1'b0;
    end else begin
      command_stb_r <= ctrl_wr;
      if (ctrl_wr) begin
        command_r <= wr_bus_r[THBP_BYTE_W-1:0];
      end
    end
  end

  // A load-pointer command sets the pointer; sequencing is left to the core.
  // Each data access in 8-bit mode flips the byte half accessed.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_r     <= THBP_PTR_RST;
      hi_byte_r <= 1'b0;
    end else if (ctrl_wr && (wr_bus_r[7:5] == THBP_CMD_LDPTR)) begin
      ptr_r     <= {3'h0, wr_bus_r[4:0]};
      hi_byte_r <= 1'b0;
    end else if ((data_wr || (rd_fire && cd_s == THBP_PORT_DATA))
                 && !mm_r[THBP_WIDTH_BIT]) begin
      hi_byte_r <= !hi_byte_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-port register space.

  // Registers reached through the pointer; the master mode word is separate.
  logic [THBP_BUS_W-1:0] regs_r [THBP_NREG];
  logic [THBP_BUS_W-1:0] wr_word;

  // Merge one byte into a stored word in 8-bit mode.
  function automatic logic [15:0] merge_byte(input logic [15:0] old_w,
                                             input logic [7:0]  b,
                                             input logic        hi);
    merge_byte = hi ? {b, old_w[7:0]} : {old_w[15:8], b};
  endfunction

  // indirect access: the pointer selects the register word.
  always_comb begin
    if (mm_r[THBP_WIDTH_BIT]) begin
      wr_word = wr_bus_r;
    end else if (ptr_r == THBP_PTR_MM) begin
      wr_word = merge_byte(mm_r, wr_bus_r[7:0], hi_byte_r);
    end else begin
      wr_word = merge_byte(regs_r[ptr_r], wr_bus_r[7:0], hi_byte_r);
    end
  end

  // width reset: master mode clears, leaving the port 8 bits wide.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mm_r <= THBP_MM_RST;
    end else if (data_wr && ptr_r == THBP_PTR_MM) begin
      mm_r <= wr_word;
    end
  end

  // pointer target: data writes go where the pointer says.
  always_ff @(posedge core_clk_in) begin
    if (data_wr && ptr_r != THBP_PTR_MM) begin
      regs_r[ptr_r] <= wr_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and outputs.

  // Read data register and drive enable.
  logic [THBP_BUS_W-1:0] rd_word;
  logic [THBP_BUS_W-1:0] rd_data_r;

  // status read: control reads return the status byte.
  always_comb begin
    if (cd_s == THBP_PORT_CTRL) begin
      rd_word = {THBP_ZERO8, status_in};
    end else if (ptr_r == THBP_PTR_MM) begin
      rd_word = mm_r;
    end else begin
      rd_word = regs_r[ptr_r];
    end
    // narrow bus: 8-bit mode shows one byte on the low lines.
    // The status byte is not subject to the data-port byte toggle.
    if (!mm_r[THBP_WIDTH_BIT] && cd_s == THBP_PORT_DATA) begin
      rd_word = {THBP_ZERO8, hi_byte_r ? rd_word[15:8] : rd_word[7:0]};
    end
  end

  // Read data is refreshed every cycle, whether or not a read is in progress.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_r <= THBP_ZERO16;
    end else begin
      rd_data_r <= rd_word;
    end
  end

  // The bus is driven from the cycle after a qualified read is seen until one cycle after it ends; in 8-bit mode
  // the upper lines are driven low, as the one enable covers all 16 lines.
  assign host_bus_line_out    = rd_data_r;
  assign host_bus_line_oe_out = rd_act_r;

  // extra gates: low on lines 8-12 disables that counter's gating.
  // upper lines high: the host keeps 13-15 high, so they are unread.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gate_enable_out <= '1;
    end else if (mm_r[THBP_WIDTH_BIT]) begin
      gate_enable_out <= '1;
    end else begin
      gate_enable_out <= bus_s[THBP_GATE_LO +: NCNT];
    end
  end

  assign command_out       = command_r;
  assign command_stb_out   = command_stb_r;
  assign data_ptr_out      = ptr_r;
  assign bus_width_bit_out = mm_r[THBP_WIDTH_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_cs_gates_wr : assert property (@(posedge core_clk_in)
    disable iff (rst_in) cs_n_s |=> !wr_act_r && !rd_act_r)
    else $error("strobe taken while chip select high");
  chk_ctrl_loads_cmd : assert property (@(posedge core_clk_in)
    disable iff (rst_in) ctrl_wr |=> command_r == $past(wr_bus_r[7:0]))
    else $error("command register not loaded");
  chk_cmd_stb_pulse : assert property (@(posedge core_clk_in)
    disable iff (rst_in) command_stb_r |=> !command_stb_r)
    else $error("command strobe longer than one cycle");
  chk_status_read : assert property (@(posedge core_clk_in)
    disable iff (rst_in) rd_act && cd_s && !mm_r[THBP_WIDTH_BIT]
      && $stable(status_in) && $stable(cd_s)
    |=> host_bus_line_out[7:0] == $past(status_in))
    else $error("status not on bus");
  chk_narrow_hi_zero : assert property (@(posedge core_clk_in)
    disable iff (rst_in) !mm_r[THBP_WIDTH_BIT]
      |-> host_bus_line_out[15:8] == THBP_ZERO8
          || $past(mm_r[THBP_WIDTH_BIT]))
    else $error("upper byte driven in narrow mode");
  chk_gate_follow : assert property (@(posedge core_clk_in)
    disable iff (rst_in) !mm_r[THBP_WIDTH_BIT] && $stable(mm_r)
    |=> gate_enable_out == $past(bus_s[THBP_GATE_LO +: NCNT]))
    else $error("gate enables not following bus");
  chk_data_target : assert property (@(posedge core_clk_in)
    disable iff (rst_in) data_wr && ptr_r == THBP_PTR_MM
    |=> mm_r == $past(wr_word))
    else $error("master mode not written");
  chk_oe_read_only : assert property (@(posedge core_clk_in)
    disable iff (rst_in) host_bus_line_oe_out |-> $past(rd_act))
    else $error("bus driven without read");
  cov_ctrl_wr : cover property (@(posedge core_clk_in) ctrl_wr);
  cov_data_wr : cover property (@(posedge core_clk_in) data_wr);
  cov_wide : cover property (@(posedge core_clk_in) mm_r[THBP_WIDTH_BIT]);
  cov_read : cover property (@(posedge core_clk_in) rd_fire);
endmodule
`default_nettype wire

// ===== thbp_host.sv
// Host processor model that drives the timer port strobes and bus pins.
// Assumes a single caller process and the port's 10 MHz core clock.
`default_nettype none
module thbp_host
  import thbp_pkg::*;
(
  // Clock.
  input  wire logic                  core_clk_in,
  // Device side of the shared bus.
  input  wire logic [THBP_BUS_W-1:0] dev_bus_in,
  input  wire logic                  dev_oe_in,
  // Host pins.
  output logic                       chip_sel_n_out,
  output logic                       rd_n_out,
  output logic                       wr_n_out,
  output logic                       ctrl_data_out,
  output logic      [THBP_BUS_W-1:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv_r;    // Low byte the host drives.
  logic [7:0] hi_r;     // Upper byte for 16-bit writes.
  logic       drv_en_r; // High while the host drives data.
  logic [4:0] gate_r;   // Extra gate levels in 8-bit mode.
  logic       wide_r;   // High once the bus is 16 bits wide.
  logic [7:0] flt_r;    // Released lines wander, never keep old data.
  initial begin
    {chip_sel_n_out, rd_n_out, wr_n_out, ctrl_data_out} = 4'hF;
    {drv_r, hi_r, drv_en_r, wide_r} = '0;
    gate_r = 5'h1F;
    flt_r = 8'h5A;
  end
  always @(posedge core_clk_in) flt_r <= ~flt_r;
  always_comb begin
    bus_out[7:0] = dev_oe_in ? dev_bus_in[7:0] : drv_en_r ? drv_r : flt_r;
    if (!wide_r) bus_out[15:8] = {3'h7, gate_r};
    else if (dev_oe_in) bus_out[15:8] = dev_bus_in[15:8];
    else bus_out[15:8] = drv_en_r ? hi_r : ~flt_r;
  end
  // Changes the gate levels and the width the host assumes.
  task automatic set_mode(input logic w, input logic [4:0] g);
    @(posedge core_clk_in);
    wide_r <= w;
    gate_r <= g;
  endtask
  task automatic cyc(input logic cs, input logic rd, input logic cd,
                     input logic [15:0] v, output logic [15:0] q,
                     output logic ok);
    int n;
    ok = 1'b1;
    q = '0;
    @(posedge core_clk_in);
    chip_sel_n_out <= ~cs;
    ctrl_data_out <= cd;
    rd_n_out <= ~rd;
    wr_n_out <= rd;
    {hi_r, drv_r} <= v;
    drv_en_r <= ~rd;
    // A read is held until the device answers or 12 cycles pass, then its data is taken.
    if (rd && cs) begin
      n = 0;
      do begin
        @(posedge core_clk_in);
        n++;
      end while (!dev_oe_in && n < 12);
      ok = dev_oe_in;
      q = bus_out;
    end else begin
      repeat (4) @(posedge core_clk_in);
    end
    chip_sel_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    drv_en_r <= 1'b0;
    repeat (5) @(posedge core_clk_in);
  endtask
endmodule
`default_nettype wire

// ===== thbp_port_tb.sv
// Self-checking bench for the timer host bus port.
// Assumes the host model above drives every strobe and bus pin.
`default_nettype none
module thbp_port_tb;
  import thbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n, rd_n, wr_n, cd, oe, stb, wide;
  logic [15:0] bus, dout;
  logic [7:0]  status, cmd, ptr;
  logic [4:0]  gate;
  int          n_fail = 0, num_checks = 0, n_stb = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (stb === 1'b1) n_stb++;
  thbp_host thbp_host_inst (.core_clk_in(clk), .dev_bus_in(dout),
    .dev_oe_in(oe), .chip_sel_n_out(cs_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .ctrl_data_out(cd), .bus_out(bus));
  thbp_port thbp_port_inst (.core_clk_in(clk), .rst_in(rst),
    .chip_sel_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .ctrl_data_in(cd), .host_bus_line_in(bus), .host_bus_line_out(dout),
    .host_bus_line_oe_out(oe), .status_in(status), .command_out(cmd),
    .command_stb_out(stb), .data_ptr_out(ptr), .bus_width_bit_out(wide),
    .gate_enable_out(gate));
  // Compares one value and counts it.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Writes one control byte and checks the model against the port.
  task automatic ctrl_wr(input logic [7:0] v, inout int ec, ep, es);
    logic [15:0] q;
    logic        ok;
    thbp_host_inst.cyc(1'b1, 1'b0, THBP_PORT_CTRL, {8'h00, v}, q, ok);
    ec = v;
    es++;
    if (v[7:5] == THBP_CMD_LDPTR) ep = v[4:0];
    check(16'(cmd), 16'(ec));
    check(16'(ptr), 16'(ep));
    check(16'(n_stb), 16'(es));
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    logic [15:0] q;
    logic        ok;
    logic [7:0]  b0, b1;
    int          ec, ep, es;
    ec = 0;
    ep = 0;
    es = 0;
    status = 8'h00;
    void'($urandom(85));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check(16'(wide), 16'h0000);
    check(16'(gate), 16'h001F);
    check({cmd, ptr}, 16'h0000);
    for (int i = 0; i < 6; i++)
      ctrl_wr(8'($urandom) & (i < 3 ? 8'h1F : 8'hFF), ec, ep, es);
    thbp_host_inst.cyc(1'b0, 1'b0, THBP_PORT_CTRL, 16'h00C3, q, ok);
    check({cmd, 8'(n_stb)}, {8'(ec), 8'(es)});
    @(posedge clk) status <= 8'($urandom);
    thbp_host_inst.cyc(1'b1, 1'b1, THBP_PORT_CTRL, 16'h0000, q, ok);
    if (!ok) n_fail++;
    check(16'(q[7:0]), 16'(status));
    thbp_host_inst.set_mode(1'b0, 5'h0A);
    repeat (5) @(posedge clk);
    check(16'(gate), 16'h000A);
    thbp_host_inst.set_mode(1'b0, 5'h1F);
    // narrow bytes stored and read back through the pointer
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    ctrl_wr(8'h09, ec, ep, es);
    thbp_host_inst.cyc(1'b1, 1'b0, THBP_PORT_DATA, {8'h00, b0}, q, ok);
    thbp_host_inst.cyc(1'b1, 1'b0, THBP_PORT_DATA, {8'h00, b1}, q, ok);
    thbp_host_inst.cyc(1'b1, 1'b1, THBP_PORT_DATA, 16'h0000, q, ok);
    check({q[7:0], 8'(ok)}, {b0, 8'h01});
    thbp_host_inst.cyc(1'b1, 1'b1, THBP_PORT_DATA, 16'h0000, q, ok);
    check({q[7:0], 8'(ok)}, {b1, 8'h01});
    ctrl_wr(THBP_PTR_MM, ec, ep, es);
    thbp_host_inst.cyc(1'b1, 1'b0, THBP_PORT_DATA, 16'h0000, q, ok);
    thbp_host_inst.cyc(1'b1, 1'b0, THBP_PORT_DATA, 16'h0040, q, ok);
    check(16'(wide), 16'h0001);
    thbp_host_inst.set_mode(1'b1, 5'h1F);
    ctrl_wr(THBP_PTR_MM, ec, ep, es);
    thbp_host_inst.cyc(1'b1, 1'b1, THBP_PORT_DATA, 16'h0000, q, ok);
    check(q, 16'h4000);
    check(16'(ok), 16'h0001);
    thbp_host_inst.cyc(1'b1, 1'b0, THBP_PORT_DATA, 16'h0000, q, ok);
    check(16'(wide), 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
